// >>> dv/uflb_ctrl_tb.sv
// Self-checking bench for the line control block
`include "uflb_params.svh"
module uflb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tx_frontend_idle = 1'h1;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [4:0] tx_fifo_level = 5'h00, rx_fifo_level = 5'h00;
	logic cts_on = 1'h0, dsr_on = 1'h0, tx_shift_bit, tx_ir_bit, cts_n_pin, dsr_n_pin;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, k;
	logic fifo_enable, fifo_flush, rx_soft_reset, tx_soft_reset, tx_low_event;
	logic rx_high_event, tx_idle_flag, tx_empty_event, parity_enable, parity_forced;
	logic parity_value, even_parity_sel, serial_out_pin, infrared_tx_pin, dtr_n_pin;
	logic rts_n_pin, modem_dsr, modem_cts, bank_reserved;
	logic [3:0] char_bits;
	logic [2:0] tx_stop_halves, bank_selected;
	logic [7:0] f;
	int bad_count = 0, cmp_count = 0, n_rsr = 0, n_tsr = 0, n_fl = 0, n_ir = 0, i, c;
	logic [4:0] rt [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
	logic [4:0] tt [4] = '{5'h01, 5'h03, 5'h09, 5'h0d};
	logic [7:0] bv [12] = '{8'h00, 8'h80, 8'hc2, 8'hc1, 8'he0, 8'he4, 8'he8, 8'hec,
		8'hf0, 8'hf4, 8'hf8, 8'hc0};
	logic [3:0] bk [12] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h8};
	logic [7:0] cv [3] = '{8'h01, 8'h03, 8'h01};
	logic [7:0] mv [3] = '{8'h40, 8'h40, 8'h60};
	logic [31:0] iv [3] = '{32'h20, 32'h02, 32'h02};
	uflb_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tx_fifo_level, .rx_fifo_level, .tx_frontend_idle, .tx_shift_bit,
		.tx_ir_bit, .cts_n_pin, .dsr_n_pin, .fifo_enable, .fifo_flush, .rx_soft_reset,
		.tx_soft_reset, .tx_low_event, .rx_high_event, .tx_idle_flag, .tx_empty_event,
		.char_bits, .tx_stop_halves, .parity_enable, .parity_forced, .parity_value,
		.even_parity_sel, .serial_out_pin, .infrared_tx_pin, .dtr_n_pin, .rts_n_pin,
		.modem_dsr, .modem_cts, .bank_selected, .bank_reserved);
	uflb_line_model far (.aclk, .cts_on, .dsr_on, .cts_n_pin, .dsr_n_pin, .tx_shift_bit,
		.tx_ir_bit);
	always #2 aclk = !aclk;
	// Pulse counters so a stuck or doubled pulse shows up
	always @(posedge aclk)
	begin
		if (rx_soft_reset === 1'h1) n_rsr++;
		if (tx_soft_reset === 1'h1) n_tsr++;
		if (fifo_flush === 1'h1) n_fl++;
		if (infrared_tx_pin === 1'h1) n_ir++;
	end
	// ******
	// Shared tasks
	// ******
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic tmo(input int n);
		if (n >= 50)
		begin
			bad_count++;
			end_of_test();
		end
	endtask : tmo
	// Extra edge after each answer so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		tmo(n);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		tmo(n);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rdr
	// ******
	// Scenarios
	// ******
	task automatic t_regs();
		rdr(`UFLB_OFF_SHADOW);
		chk("shadow reset", 32'h0, rd);
		wr(`UFLB_OFF_LINE_BANK, 8'h1b);
		chk("write okay", 32'h0, {30'h0, rr});
		rdr(`UFLB_OFF_LINE_BANK);
		chk("bank read", 32'h1b, rd);
		wr(`UFLB_OFF_LINE_BANK, 8'he4);
		rdr(`UFLB_OFF_SHADOW);
		chk("format kept", 32'h1b, rd);
		for (i = 0; i < 12; i++)
		begin
			wr(`UFLB_OFF_LINE_BANK, bv[i]);
			if (bk[i] == 4'h8)
				chk("bank reserved", 1'h1, bank_reserved);
			else
				chk("bank", bk[i][2:0], bank_selected);
		end
		rdr(8'h20);
		chk("unmapped", 32'h2, {rd[29:0], rr});
		wr(8'h20, 8'h00);
		chk("write unmapped", 32'h2, {30'h0, rr});
	endtask : t_regs
	task automatic t_format();
		for (i = 0; i < 64; i++)
		begin
			f = {2'h0, i[5:0]};
			wr(`UFLB_OFF_LINE_BANK, f);
			chk("char bits", 4'h5 + f[1:0], char_bits);
			chk("stop", f[2] ? (f[1:0] == 2'h0 ? 3'h3 : 3'h4) : 3'h2, tx_stop_halves);
			chk("parity on", f[3], parity_enable);
			if (f[3]) chk("parity even", f[4], even_parity_sel);
			if (f[3]) chk("parity stick", f[5], parity_forced);
			if (f[3] && f[5]) chk("parity level", !f[4], parity_value);
		end
	endtask : t_format
	task automatic t_fifo();
		wr(`UFLB_OFF_EVT_FIFO, 8'h07);
		chk("fifo on", 1'h1, fifo_enable);
		chk("rx resets", 32'h1, n_rsr);
		chk("tx resets", 32'h1, n_tsr);
		rdr(`UFLB_OFF_EVT_FIFO);
		chk("event fifo bits", 32'hc0, {rd[31:6], 6'h00});
		wr(`UFLB_OFF_EVT_FIFO, 8'h00);
		chk("fifo off", 32'h1, {fifo_enable, n_fl[30:0]});
		for (i = 0; i < 8; i++)
		begin
			k = i[1:0];
			wr(`UFLB_OFF_CTL, {7'h00, i[2]});
			wr(`UFLB_OFF_EVT_FIFO, {k, k, 4'h1});
			rx_fifo_level <= rt[k] - 5'h01;
			tx_fifo_level <= tt[k];
			@(posedge aclk);
			chk("rx below", 1'h0, rx_high_event);
			chk("tx at", 1'h0, tx_low_event);
			rx_fifo_level <= rt[k];
			tx_fifo_level <= tt[k] - 5'h01;
			@(posedge aclk);
			chk("rx at", 1'h1, rx_high_event);
			chk("tx below", i[2], tx_low_event);
		end
		tx_fifo_level <= 5'h00;
		rx_fifo_level <= 5'h00;
	endtask : t_fifo
	task automatic t_modes();
		wr(`UFLB_OFF_LINE_BANK, 8'h00);
		wr(`UFLB_OFF_MODEM, 8'hc0);
		c = n_fl;
		wr(`UFLB_OFF_EVT_FIFO, 8'h00);
		chk("cir fifo", 32'h80000000, {fifo_enable, 31'(n_fl - c)});
		chk("cir length", 4'h8, char_bits);
		chk("cir empty", 1'h1, tx_empty_event);
		rdr(`UFLB_OFF_EVT_FIFO);
		chk("ext events", 32'h22, rd);
		wr(`UFLB_OFF_MODEM, 8'h60);
		chk("sir empty", 1'h0, tx_empty_event);
	endtask : t_modes
	task automatic t_break();
		wr(`UFLB_OFF_CTL, 8'h00);
		for (i = 0; i < 50 && tx_idle_flag !== 1'h1; i++) @(posedge aclk);
		tmo(i);
		wr(`UFLB_OFF_LINE_BANK, 8'h47);
		chk("break line", 1'h0, serial_out_pin);
		chk("break format", 32'h84, {char_bits, 1'h0, tx_stop_halves});
		for (i = 0; i < 3; i++)
		begin
			wr(`UFLB_OFF_CTL, cv[i]);
			wr(`UFLB_OFF_MODEM, mv[i]);
			c = n_ir;
			repeat (32) @(posedge aclk);
			chk("ir highs", iv[i], n_ir - c);
		end
		for (i = 0; i < 50 && tx_idle_flag !== 1'h1; i++) @(posedge aclk);
		tmo(i);
		wr(`UFLB_OFF_LINE_BANK, 8'h07);
		chk("ir free", 1'h0, infrared_tx_pin);
		wr(`UFLB_OFF_CTL, 8'h00);
		chk("line free", 1'h1, serial_out_pin);
	endtask : t_break
	task automatic t_modem();
		wr(`UFLB_OFF_MODEM, 8'h01);
		chk("dtr rts", 2'h1, {dtr_n_pin, rts_n_pin});
		wr(`UFLB_OFF_MODEM, 8'h02);
		chk("dtr rts", 2'h2, {dtr_n_pin, rts_n_pin});
		cts_on <= 1'h1;
		repeat (4) @(posedge aclk);
		chk("dsr cts pins", 2'h1, {modem_dsr, modem_cts});
		wr(`UFLB_OFF_MODEM, 8'hf1);
		chk("loop", 4'he, {dtr_n_pin, rts_n_pin, modem_dsr, modem_cts});
		rdr(`UFLB_OFF_MODEM);
		chk("modem reg", 32'h11, rd);
	endtask : t_modem
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_format();
		t_fifo();
		t_modes();
		t_break();
		t_modem();
		end_of_test();
	end
endmodule : uflb_ctrl_tb

// >>> dv/uflb_line_model.sv
// Far-side line and modem model for the line control bench
module uflb_line_model
(
	input wire logic aclk,
	input wire logic cts_on,
	input wire logic dsr_on,
	output logic cts_n_pin,
	output logic dsr_n_pin,
	output logic tx_shift_bit,
	output logic tx_ir_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	// ******
	// Idle marking line, modem pins low when asserted
	// ******
	initial {cts_n_pin, dsr_n_pin, tx_shift_bit, tx_ir_bit} = 4'he;
	always @(posedge aclk)
	begin
		cts_n_pin <= !cts_on;
		dsr_n_pin <= !dsr_on;
		tx_shift_bit <= 1'h1;
		tx_ir_bit <= 1'h0;
	end
endmodule : uflb_line_model

// >>> rtl/uflb_ctrl.sv
// FIFO, line format, bank select and modem control registers behind AXI4-Lite
// Contract
// R01: Tx empty event mirrors idle in UART/ASK/CIR
// R02: FIFO enable 1 enables, 0 flushes both
// R03: CIR mode keeps FIFOs enabled, ignores bit
// R04: Rx soft reset clears, self-clears
// R05: Tx soft reset clears, self-clears
// R06: Extended: tx event below 1/3/9/13
// R07: Rx event at or above 1/4/8/14
// R08: Shared address reads bank select; shadow holds format
// R09: Bit7 low writes both, high bank only
// R10: Format and bank select reset to zero
// R11: Format bits ignored in CIR mode
// R12: Length code gives 5 to 8 bits
// R13: Stop bits 1, 1.5 or 2; rx checks one
// R14: Parity none/odd/even/one/zero from three bits
// R15: UART break holds serial output low
// R16: SIR or modulated ASK break pulses infrared
// R17: Unmodulated ASK break holds infrared high
// R18: Break touches front-end only
// R19: Host sets/clears break only when tx empty
// R20: Bank decode from bank select pattern
// R21: Terminal-ready bit drives pin or loopback ready
// R22: Send-request bit drives pin or loopback clear
// R23: Event read and FIFO write share address
// R24: Reserved bits read zero, writes ignored
`include "uflb_params.svh"
module uflb_ctrl
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [4:0] tx_fifo_level,
	input wire logic [4:0] rx_fifo_level,
	input wire logic tx_frontend_idle,
	input wire logic tx_shift_bit,
	input wire logic tx_ir_bit,
	input wire logic cts_n_pin,
	input wire logic dsr_n_pin,
	output logic fifo_enable,
	output logic fifo_flush,
	output logic rx_soft_reset,
	output logic tx_soft_reset,
	output logic tx_low_event,
	output logic rx_high_event,
	output logic tx_idle_flag,
	output logic tx_empty_event,
	output logic [3:0] char_bits,
	output logic [2:0] tx_stop_halves,
	output logic parity_enable,
	output logic parity_forced,
	output logic parity_value,
	output logic even_parity_sel,
	output logic serial_out_pin,
	output logic infrared_tx_pin,
	output logic dtr_n_pin,
	output logic rts_n_pin,
	output logic modem_dsr,
	output logic modem_cts,
	output logic [2:0] bank_selected,
	output logic bank_reserved
);
	uflb_pkg::uflb_state_t st_reg;
	uflb_pkg::uflb_state_t st_next;
	uflb_pkg::uflb_mode_t mode;
	logic ext;
	logic cir;
	logic fmt_on;
	logic brk;
	logic loop;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_wr;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] evt;
	logic [4:0] tx_thr_n;
	logic [4:0] rx_thr_n;
	logic [3:0] bank_code;

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic [4:0] thr_level(input logic rx, input logic [1:0] code);
		logic [4:0] v;
		v = 5'h01;
		case (code)
			2'h1: v = rx ? 5'h04 : 5'h03;
			2'h2: v = rx ? 5'h08 : 5'h09;
			2'h3: v = rx ? 5'h0e : 5'h0d;
			default: v = 5'h01;
		endcase
		return v;
	endfunction : thr_level

	function automatic logic [3:0] bank_of(input logic [7:0] b);
		logic [3:0] v;
		v = 4'h8;
		if (!b[7])
			v = 4'h0;
		else if (!b[6] || b[1] || b[0])
			v = 4'h1;
		else if (b[5] && !(b[4] && b[3]))
			v = {1'b0, 3'(3'h2 + {b[4], b[3], b[2]})};
		return v;
	endfunction : bank_of

	// ****************************************
	// Mode and event terms
	// ****************************************
	assign ext = st_reg.ctl[`UFLB_CTL_EXT];
	// Plain layout and reserved mode codes both run as UART
	assign mode = (ext && (st_reg.modem_line_control[`UFLB_MCR_MODE] inside {uflb_pkg::MODE_ASK,
		uflb_pkg::MODE_SIR, uflb_pkg::MODE_CIR}))
		? uflb_pkg::uflb_mode_t'(st_reg.modem_line_control[`UFLB_MCR_MODE]) : uflb_pkg::MODE_UART;
	assign cir = (mode == uflb_pkg::MODE_CIR);
	assign fmt_on = !cir; // R11
	assign brk = fmt_on && st_reg.line_format_control[`UFLB_LCR_SET_BREAK];
	assign loop = !ext && st_reg.modem_line_control[`UFLB_MCR_LOOP];
	assign tx_thr_n = thr_level(1'b0, st_reg.tx_thr);
	assign rx_thr_n = thr_level(1'b1, st_reg.rx_thr);
	assign tx_idle_flag = (tx_fifo_level == 5'h00) && tx_frontend_idle;
	assign tx_empty_event = tx_idle_flag && (mode == uflb_pkg::MODE_UART
		|| mode == uflb_pkg::MODE_ASK || cir); // R01
	assign tx_low_event = ext && (tx_fifo_level < tx_thr_n); // R06
	assign rx_high_event = fifo_enable ? (rx_fifo_level >= rx_thr_n) // R07
		: (rx_fifo_level != 5'h00);
	assign fifo_enable = st_reg.fifo_en || cir; // R03
	assign fifo_flush = st_reg.flush;
	assign rx_soft_reset = st_reg.rx_sr;
	assign tx_soft_reset = st_reg.tx_sr;

	// Extended view is one flag per source; standard view is prioritised
	always_comb
	begin
		evt = 8'h01;
		if (ext)
			evt = {2'h0, tx_empty_event, 3'h0, tx_low_event, rx_high_event}; // R24
		else if (rx_high_event)
			evt = {{2{fifo_enable}}, 6'h04};
		else if (tx_low_event || tx_idle_flag)
			evt = {{2{fifo_enable}}, 6'h02};
		else
			evt = {{2{fifo_enable}}, 6'h01};
	end

	// ****************************************
	// Line format outputs
	// ****************************************
	assign char_bits = fmt_on ? 4'(4'h5 + {2'h0, st_reg.line_format_control[`UFLB_LCR_WLS]}) : 4'h8; // R12
	always_comb
	begin
		tx_stop_halves = 3'h2; // R13
		if (fmt_on && st_reg.line_format_control[`UFLB_LCR_STB])
			tx_stop_halves = (st_reg.line_format_control[`UFLB_LCR_WLS] == 2'h0) ? 3'h3 : 3'h4;
	end
	assign parity_enable = fmt_on && st_reg.line_format_control[`UFLB_LCR_PEN]; // R14
	assign even_parity_sel = st_reg.line_format_control[`UFLB_LCR_EPS];
	assign parity_forced = parity_enable && st_reg.line_format_control[`UFLB_LCR_STICK_PARITY];
	assign parity_value = !st_reg.line_format_control[`UFLB_LCR_EPS];

	// ****************************************
	// Transmit front-end and modem pins
	// ****************************************
	// Break only overrides the pins, the shifter keeps timing characters
	assign serial_out_pin = (brk && mode == uflb_pkg::MODE_UART) ? 1'b0 // R15 R18
		: tx_shift_bit;
	always_comb
	begin
		infrared_tx_pin = tx_ir_bit; // R18
		if (brk && (mode == uflb_pkg::MODE_SIR
			|| (mode == uflb_pkg::MODE_ASK && st_reg.ctl[`UFLB_CTL_IMOD])))
			infrared_tx_pin = st_reg.pulse; // R16
		else if (brk && mode == uflb_pkg::MODE_ASK)
			infrared_tx_pin = 1'b1; // R17
	end
	// Pins go inactive in loopback so the far end sees no stray handshake
	assign dtr_n_pin = loop || !st_reg.modem_line_control[`UFLB_MCR_DTR]; // R21
	assign rts_n_pin = loop || !st_reg.modem_line_control[`UFLB_MCR_RTS]; // R22
	assign modem_dsr = loop ? st_reg.modem_line_control[`UFLB_MCR_DTR] : !st_reg.dsr_s[1]; // R21
	assign modem_cts = loop ? st_reg.modem_line_control[`UFLB_MCR_RTS] : !st_reg.cts_s[1]; // R22
	assign bank_code = bank_of(st_reg.register_bank_select); // R20
	assign bank_selected = bank_code[2:0]; // R20
	assign bank_reserved = bank_code[3];

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rdata = {24'h0, st_reg.rdata};
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign do_wr = (st_reg.aw_have || aw_hs) && (st_reg.w_have || w_hs);
	assign wr_addr = st_reg.aw_have ? st_reg.aw_addr : s_axi_awaddr;
	assign wr_data = st_reg.w_have ? st_reg.w_data : s_axi_wdata[7:0];

	always_comb
	begin
		st_next = st_reg;
		st_next.rx_sr = 1'b0; // R04
		st_next.tx_sr = 1'b0; // R05
		st_next.flush = 1'b0;
		st_next.cts_s = {st_reg.cts_s[0], cts_n_pin};
		st_next.dsr_s = {st_reg.dsr_s[0], dsr_n_pin};
		st_next.pulse = 1'b0;
		st_next.pdiv = 8'(st_reg.pdiv + 8'h01);
		if (st_reg.pdiv == 8'(`UFLB_IR_DIV - 1))
		begin
			st_next.pdiv = 8'h00;
			st_next.pulse = 1'b1;
		end
		if (aw_hs)
		begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (w_hs)
		begin
			st_next.w_have = 1'b1;
			st_next.w_data = s_axi_wdata[7:0];
			st_next.w_lane0 = s_axi_wstrb[0];
		end
		if (do_wr)
		begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `UFLB_RESP_OKAY;
			if ((st_reg.w_have ? st_reg.w_lane0 : s_axi_wstrb[0]))
			begin
				case (wr_addr)
					`UFLB_OFF_EVT_FIFO: // R23
					begin
						if (!cir) // R03
						begin
							st_next.fifo_en = wr_data[`UFLB_FCR_FEN]; // R02
							st_next.flush = !wr_data[`UFLB_FCR_FEN]; // R02
						end
						st_next.rx_sr = wr_data[`UFLB_FCR_RX_SOFT_RESET]; // R04
						st_next.tx_sr = wr_data[`UFLB_FCR_TX_SOFT_RESET]; // R05
						st_next.tx_thr = wr_data[`UFLB_FCR_TXTH];
						st_next.rx_thr = wr_data[`UFLB_FCR_RXTH];
					end
					`UFLB_OFF_LINE_BANK:
					begin
						st_next.register_bank_select = wr_data; // R09
						if (!wr_data[`UFLB_LCR_BANK_SEL_ENABLE])
							st_next.line_format_control = wr_data; // R09
					end
					`UFLB_OFF_MODEM:
						st_next.modem_line_control = ext ? wr_data : (wr_data & `UFLB_MCR_STD_MASK); // R24
					`UFLB_OFF_SHADOW:
						st_next.line_format_control = wr_data;
					`UFLB_OFF_CTL:
						st_next.ctl = wr_data[1:0];
					default:
						st_next.bresp = `UFLB_RESP_SLVERR;
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (ar_hs)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `UFLB_RESP_OKAY;
			case (s_axi_araddr)
				`UFLB_OFF_EVT_FIFO: st_next.rdata = evt; // R23
				`UFLB_OFF_LINE_BANK: st_next.rdata = st_reg.register_bank_select; // R08
				`UFLB_OFF_MODEM: st_next.rdata = ext ? st_reg.modem_line_control : (st_reg.modem_line_control & `UFLB_MCR_STD_MASK); // R24
				`UFLB_OFF_SHADOW: st_next.rdata = st_reg.line_format_control; // R08
				`UFLB_OFF_CTL: st_next.rdata = {6'h00, st_reg.ctl};
				default:
				begin
					st_next.rdata = 8'h00;
					st_next.rresp = `UFLB_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '0;
			st_reg.line_format_control <= `UFLB_LCR_RST; // R10
			st_reg.register_bank_select <= `UFLB_BSR_RST; // R10
			st_reg.modem_line_control <= `UFLB_MCR_RST;
			st_reg.cts_s <= 2'h3;
			st_reg.dsr_s <= 2'h3;
		end
		else
			st_reg <= st_next;
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_rx_sr_pulse;
		@(posedge aclk) disable iff (!aresetn)
		rx_soft_reset |=> !rx_soft_reset;
	endproperty
	a_rx_sr_pulse: assert property (p_rx_sr_pulse) else $error("rx reset not one cycle"); // R04

	property p_tx_sr_pulse;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && wr_addr == `UFLB_OFF_EVT_FIFO && wr_data[`UFLB_FCR_TX_SOFT_RESET]
			&& (st_reg.w_have ? st_reg.w_lane0 : s_axi_wstrb[0]))
		|=> tx_soft_reset ##1 !tx_soft_reset;
	endproperty
	a_tx_sr_pulse: assert property (p_tx_sr_pulse) else $error("tx reset pulse wrong"); // R05

	property p_bank_only;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && wr_addr == `UFLB_OFF_LINE_BANK && wr_data[`UFLB_LCR_BANK_SEL_ENABLE])
		|=> (st_reg.line_format_control == $past(st_reg.line_format_control)) && (st_reg.register_bank_select == $past(wr_data));
	endproperty
	a_bank_only: assert property (p_bank_only) else $error("format changed by bank write"); // R09

	property p_read_bank;
		@(posedge aclk) disable iff (!aresetn)
		(ar_hs && s_axi_araddr == `UFLB_OFF_LINE_BANK)
		|=> s_axi_rvalid && (s_axi_rdata == {24'h0, $past(st_reg.register_bank_select)});
	endproperty
	a_read_bank: assert property (p_read_bank) else $error("shared read not bank select"); // R08

	property p_uart_break;
		@(posedge aclk) disable iff (!aresetn)
		(!ext && st_reg.line_format_control[`UFLB_LCR_SET_BREAK]) |-> !serial_out_pin;
	endproperty
	a_uart_break: assert property (p_uart_break) else $error("break not driving low"); // R15

	property p_ask_steady;
		@(posedge aclk) disable iff (!aresetn)
		(brk && mode == uflb_pkg::MODE_ASK && !st_reg.ctl[`UFLB_CTL_IMOD]) |-> infrared_tx_pin;
	endproperty
	a_ask_steady: assert property (p_ask_steady) else $error("ask break not high"); // R17

	property p_cir_fifo;
		@(posedge aclk) disable iff (!aresetn)
		cir |-> fifo_enable && !fifo_flush;
	endproperty
	a_cir_fifo: assert property (p_cir_fifo) else $error("fifo off in cir mode"); // R03

	property p_tx_thr;
		@(posedge aclk) disable iff (!aresetn)
		tx_low_event == (ext && ((st_reg.tx_thr == 2'h0 && tx_fifo_level < 5'h01)
			|| (st_reg.tx_thr == 2'h1 && tx_fifo_level < 5'h03)
			|| (st_reg.tx_thr == 2'h2 && tx_fifo_level < 5'h09)
			|| (st_reg.tx_thr == 2'h3 && tx_fifo_level < 5'h0d)));
	endproperty
	a_tx_thr: assert property (p_tx_thr) else $error("tx event outside threshold"); // R06

	property p_empty_ev;
		@(posedge aclk) disable iff (!aresetn)
		(tx_fifo_level == 5'h00 && tx_frontend_idle
			&& !(ext && st_reg.modem_line_control[`UFLB_MCR_MODE] == 3'b011)) |-> tx_empty_event;
	endproperty
	a_empty_ev: assert property (p_empty_ev) else $error("empty event missing"); // R01
endmodule : uflb_ctrl

// >>> rtl/uflb_params.svh
// Offsets, field positions, reset values and timing for the line control block
`ifndef UFLB_PARAMS_SVH
`define UFLB_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define UFLB_OFF_EVT_FIFO 8'h00
`define UFLB_OFF_LINE_BANK 8'h04
`define UFLB_OFF_MODEM 8'h08
`define UFLB_OFF_SHADOW 8'h0c
`define UFLB_OFF_CTL 8'h10
// ****************************************
// Field positions
// ****************************************
`define UFLB_FCR_FEN 0
`define UFLB_FCR_RX_SOFT_RESET 1
`define UFLB_FCR_TX_SOFT_RESET 2
`define UFLB_FCR_TXTH 5:4
`define UFLB_FCR_RXTH 7:6
`define UFLB_LCR_WLS 1:0
`define UFLB_LCR_STB 2
`define UFLB_LCR_PEN 3
`define UFLB_LCR_EPS 4
`define UFLB_LCR_STICK_PARITY 5
`define UFLB_LCR_SET_BREAK 6
`define UFLB_LCR_BANK_SEL_ENABLE 7
`define UFLB_LCR_FMT 6:0
`define UFLB_MCR_DTR 0
`define UFLB_MCR_RTS 1
`define UFLB_MCR_LOOP 4
`define UFLB_MCR_MODE 7:5
`define UFLB_MCR_STD_MASK 8'h1f
`define UFLB_CTL_EXT 0
`define UFLB_CTL_IMOD 1
// ****************************************
// Reset values, answers and timing
// ****************************************
`define UFLB_LCR_RST 8'h00
`define UFLB_BSR_RST 8'h00
`define UFLB_MCR_RST 8'h00
`define UFLB_RESP_OKAY 2'h0
`define UFLB_RESP_SLVERR 2'h2
`define UFLB_IR_PULSE_NS 64
`define UFLB_CLK_NS 4
`define UFLB_IR_DIV (`UFLB_IR_PULSE_NS / `UFLB_CLK_NS)
`endif

// >>> rtl/uflb_pkg.sv
// Types for the line control block
package uflb_pkg;
	typedef enum logic [2:0]
	{
		MODE_UART = 3'b000,
		MODE_ASK = 3'b010,
		MODE_SIR = 3'b011,
		MODE_CIR = 3'b110
	} uflb_mode_t;
	typedef struct packed
	{
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic fifo_en;
		logic [1:0] tx_thr;
		logic [1:0] rx_thr;
		logic rx_sr;
		logic tx_sr;
		logic flush;
		logic [7:0] line_format_control;
		logic [7:0] register_bank_select;
		logic [7:0] modem_line_control;
		logic [1:0] ctl;
		logic [7:0] pdiv;
		logic pulse;
		logic [1:0] cts_s;
		logic [1:0] dsr_s;
	} uflb_state_t;
endpackage : uflb_pkg
